// ==== design/sbc_debug_pkg.sv ====
// Package for the debug-mode watchdog bypass block: SPI byte fields, mode codes, timings.
// Assumes one 200 MHz clock; shared by the mode controller and its helpers.
package sbc_debug_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_PERIOD_PS = 5000;
  localparam int NORMAL_REQUEST_MS = 350;
  localparam int RESET_PULSE_DURATION_US = 15000;
  localparam int WATCHDOG_PERIOD_MS = 100;
  localparam int TICK_US = 1;
  localparam int TICK_CYCLES = (TICK_US * 1000000) / CLK_PERIOD_PS;
  localparam int NORMAL_REQUEST_TICKS = NORMAL_REQUEST_MS * 1000 / TICK_US;
  localparam int RESET_PULSE_TICKS = RESET_PULSE_DURATION_US / TICK_US;
  localparam int WATCHDOG_PERIOD_TICKS = WATCHDOG_PERIOD_MS * 1000 / TICK_US;

  // ****************************************************************
  // SPI byte layout
  // ****************************************************************
  localparam int ADDR_MSB = 7;
  localparam int ADDR_LSB = 4;
  localparam int DATA_MSB = 3;
  localparam int DATA_LSB = 0;
  localparam logic [3:0] ADDR_MODE_CONTROL = 4'h1;
  localparam logic [3:0] ADDR_WATCHDOG_TIMING = 4'h2;

  // Mode-control data values
  localparam logic [3:0] MODE_DATA_ARM = 4'h0;
  localparam logic [3:0] MODE_DATA_NORMAL = 4'h5;
  localparam logic [3:0] MODE_DATA_NORMAL_MASK = 4'h7;
  localparam logic [3:0] MODE_DATA_STANDBY = 4'h6;
  localparam logic [3:0] MODE_DATA_STOP = 4'hC;
  localparam logic [3:0] MODE_DATA_SLEEP = 4'hE;

  // ****************************************************************
  // Modes
  // ****************************************************************
  typedef enum logic [3:0] {
    MODE_RESET = 4'h0,
    MODE_NORMAL_REQUEST = 4'h1,
    MODE_NORMAL = 4'h2,
    MODE_STANDBY = 4'h3,
    MODE_STOP = 4'h4,
    MODE_SLEEP = 4'h5,
    MODE_NORMAL_DEBUG = 4'h6,
    MODE_STANDBY_DEBUG = 4'h7,
    MODE_STOP_DEBUG = 4'h8,
    MODE_SLEEP_DEBUG = 4'h9
  } mode_t;

endpackage

// ==== design/spi_cmd_if.sv ====
// Decoded SPI command carrier between the byte decoder and the mode controller.
// Assumes single-clock operation; strobes are one cycle wide.
`timescale 1ns/1ps
interface spi_cmd_if;
  logic mode_write;
  logic mode_read;
  logic timing_write;
  logic [3:0] data;

  modport source (output mode_write, output mode_read, output timing_write, output data);
  modport sink (input mode_write, input mode_read, input timing_write, input data);
endinterface

// ==== design/spi_byte_decode.sv ====
// Splits a received SPI byte into register address and data strobes.
// Assumes a one-cycle byte-valid strobe with the byte synchronous to the clock.
`timescale 1ns/1ps
module spi_byte_decode
  import sbc_debug_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic byte_valid,
  input wire logic byte_write,
  input wire logic [7:0] byte_in,
  spi_cmd_if.source cmd
);

  logic [3:0] addr;
  logic is_mode;
  logic is_timing;

  assign addr = byte_in[ADDR_MSB:ADDR_LSB];
  assign is_mode = (addr == ADDR_MODE_CONTROL);
  assign is_timing = (addr == ADDR_WATCHDOG_TIMING);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd.mode_write <= 1'b0;
      cmd.mode_read <= 1'b0;
      cmd.timing_write <= 1'b0;
      cmd.data <= 4'h0;
    end else begin
      cmd.mode_write <= byte_valid && byte_write && is_mode;
      cmd.mode_read <= byte_valid && !byte_write && is_mode;
      cmd.timing_write <= byte_valid && byte_write && is_timing;
      cmd.data <= byte_in[DATA_MSB:DATA_LSB];
    end
  end

endmodule // spi_byte_decode

// ==== design/sbc_debug_ctrl.sv ====
// Mode controller with debug-mode watchdog bypass.
// Assumes bytes and status inputs synchronous to MCLK; RESET_N is power-up reset.
//
// Behaviour
// - After power-up the battery-fail flag is set and the device enters Normal Request.
// - A watchdog timing write in Normal Request moves the device to Normal.
// - A mode-control write of 0000 (byte 0001 0000) in Normal or Standby arms debug while the battery-fail flag is set.
// - Once armed, a mode-control write 0001 x101 selects Normal Debug.
// - If Normal Request expires the device enters Reset and then Normal Request again.
// - In any debug mode there is no watchdog servicing and no watchdog reset.
// - A mode-control write of 0000 in Normal Debug or Standby Debug leaves debug.
// - A wake-up in Stop Debug or Sleep Debug enters Normal Request for 350 ms.
// - Stop entered from debug runs without watchdog regardless of the stop bit.
// - A low main regulator output in any debug mode forces Reset.
// - Unconfigured, reset is held low for the pulse duration then released 350 ms, repeating.
// - Any watchdog timing write counts as a watchdog trigger.
`timescale 1ns/1ps
module sbc_debug_ctrl
  import sbc_debug_pkg::*;
#(
  parameter int NR_TICKS = NORMAL_REQUEST_TICKS,
  parameter int RST_TICKS = RESET_PULSE_TICKS,
  parameter int WD_TICKS = WATCHDOG_PERIOD_TICKS,
  parameter int TICK_DIV = TICK_CYCLES
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RESET_N,
  // SPI byte stream
  input wire logic SPI_BYTE_VALID,
  input wire logic SPI_BYTE_WRITE,
  input wire logic [7:0] SPI_BYTE,
  // Status inputs
  input wire logic MAIN_REGULATOR_LOW,
  input wire logic WAKE_UP,
  input wire logic WATCHDOG_IN_STOP_BIT,
  // Outputs
  output logic RESET_OUT_N,
  output logic WATCHDOG_FAIL_OUT_N,
  output logic BATTERY_FAIL,
  output logic DEBUG_ACTIVE,
  output logic [3:0] MODE
);

  // ****************************************************************
  // Decoder and tick divider
  // ****************************************************************
  spi_cmd_if cmd ();

  spi_byte_decode u_decode (
    .clk(MCLK),
    .reset_n(RESET_N),
    .byte_valid(SPI_BYTE_VALID),
    .byte_write(SPI_BYTE_WRITE),
    .byte_in(SPI_BYTE),
    .cmd(cmd)
  );

  logic tick;

  tick_divider #(.DIV(TICK_DIV)) u_tick (
    .clk(MCLK),
    .reset_n(RESET_N),
    .tick(tick)
  );

  // ****************************************************************
  // State
  // ****************************************************************
  mode_t mode_q, mode_d;
  logic [23:0] timer_q, timer_d;
  logic [23:0] wd_q, wd_d;
  logic armed_q, armed_d;
  logic batfail_q, batfail_d;
  logic wdfail_q, wdfail_d;
  logic debug_q;

  wire logic in_debug = (mode_q == MODE_NORMAL_DEBUG) || (mode_q == MODE_STANDBY_DEBUG) ||
                        (mode_q == MODE_STOP_DEBUG) || (mode_q == MODE_SLEEP_DEBUG);
  wire logic wr_arm = cmd.mode_write && (cmd.data == MODE_DATA_ARM);
  wire logic wr_ndbg = cmd.mode_write &&
                       ((cmd.data & MODE_DATA_NORMAL_MASK) == MODE_DATA_NORMAL);
  wire logic wr_sbdbg = cmd.mode_write && (cmd.data == MODE_DATA_STANDBY);
  wire logic wr_stop = cmd.mode_write && (cmd.data == MODE_DATA_STOP);
  wire logic wr_sleep = cmd.mode_write && (cmd.data == MODE_DATA_SLEEP);
  wire logic timer_done = tick && (timer_q == 24'h000000);
  wire logic wd_expired = tick && (wd_q == 24'h000000);
  // Watchdog runs only in Normal/Standby, and in Stop when its bit asks; never in debug
  wire logic wd_running = (mode_q == MODE_NORMAL) || (mode_q == MODE_STANDBY) ||
                          ((mode_q == MODE_STOP) && WATCHDOG_IN_STOP_BIT);

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    mode_d = mode_q;
    timer_d = (tick && timer_q != 24'h000000) ? timer_q - 24'h000001 : timer_q;
    wd_d = (tick && wd_q != 24'h000000) ? wd_q - 24'h000001 : wd_q;
    armed_d = armed_q;
    batfail_d = batfail_q;
    wdfail_d = wdfail_q;
    if (cmd.timing_write) begin
      wd_d = 24'(WD_TICKS - 1);
      wdfail_d = 1'b0;
    end
    if (cmd.mode_read) begin
      batfail_d = 1'b0;
    end
    case (mode_q)
      MODE_RESET: begin
        if (timer_done) begin
          mode_d = MODE_NORMAL_REQUEST;
          timer_d = 24'(NR_TICKS - 1);
        end
      end
      MODE_NORMAL_REQUEST: begin
        if (wr_ndbg && armed_q) begin
          mode_d = MODE_NORMAL_DEBUG;
        end else if (wr_sbdbg && armed_q) begin
          mode_d = MODE_STANDBY_DEBUG;
        end else if (cmd.timing_write) begin
          mode_d = MODE_NORMAL;
        end else if (timer_done) begin
          mode_d = MODE_RESET;
          timer_d = 24'(RST_TICKS - 1);
        end
      end
      MODE_NORMAL, MODE_STANDBY: begin
        if (wr_arm && batfail_q) begin
          armed_d = 1'b1;
        end else if (wr_ndbg && armed_q) begin
          mode_d = MODE_NORMAL_DEBUG;
        end else if (wr_stop) begin
          mode_d = MODE_STOP;
        end else if (wr_sleep) begin
          mode_d = MODE_SLEEP;
        end else if (cmd.mode_write && cmd.data == MODE_DATA_STANDBY) begin
          mode_d = MODE_STANDBY;
        end else if (wd_expired) begin
          mode_d = MODE_RESET;
          wdfail_d = 1'b1;
          armed_d = 1'b0;
          timer_d = 24'(RST_TICKS - 1);
        end
        if (cmd.mode_write && !wr_arm) begin
          batfail_d = 1'b0;
        end
      end
      MODE_STOP, MODE_SLEEP: begin
        if (WAKE_UP) begin
          mode_d = MODE_RESET;
          timer_d = 24'(RST_TICKS - 1);
        end else if (wd_running && wd_expired) begin
          mode_d = MODE_RESET;
          wdfail_d = 1'b1;
          timer_d = 24'(RST_TICKS - 1);
        end
      end
      MODE_NORMAL_DEBUG, MODE_STANDBY_DEBUG: begin
        if (wr_arm) begin
          mode_d = MODE_NORMAL;
          armed_d = 1'b0;
          batfail_d = 1'b0;
          wd_d = 24'(WD_TICKS - 1);
        end else if (wr_stop) begin
          mode_d = MODE_STOP_DEBUG;
        end else if (wr_sleep) begin
          mode_d = MODE_SLEEP_DEBUG;
        end else if (wr_sbdbg) begin
          mode_d = MODE_STANDBY_DEBUG;
        end else if (wr_ndbg) begin
          mode_d = MODE_NORMAL_DEBUG;
        end
      end
      MODE_STOP_DEBUG, MODE_SLEEP_DEBUG: begin
        if (WAKE_UP) begin
          mode_d = MODE_NORMAL_REQUEST;
          timer_d = 24'(NR_TICKS - 1);
        end
      end
      default: begin
        mode_d = MODE_RESET;
        timer_d = 24'(RST_TICKS - 1);
      end
    endcase
    if (in_debug && MAIN_REGULATOR_LOW) begin
      mode_d = MODE_RESET;
      armed_d = 1'b0;
      timer_d = 24'(RST_TICKS - 1);
    end
    if (mode_d == MODE_RESET && mode_q != MODE_RESET && !in_debug) begin
      armed_d = 1'b0;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mode_q <= MODE_RESET;
      timer_q <= 24'h000000;
      wd_q <= 24'h000000;
      armed_q <= 1'b0;
      batfail_q <= 1'b1;
      wdfail_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      timer_q <= timer_d;
      wd_q <= wd_d;
      armed_q <= armed_d;
      batfail_q <= batfail_d;
      wdfail_q <= wdfail_d;
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RESET_OUT_N <= 1'b0;
      WATCHDOG_FAIL_OUT_N <= 1'b1;
      BATTERY_FAIL <= 1'b1;
      DEBUG_ACTIVE <= 1'b0;
      MODE <= 4'h0;
      debug_q <= 1'b0;
    end else begin
      RESET_OUT_N <= (mode_d != MODE_RESET);
      WATCHDOG_FAIL_OUT_N <= !wdfail_d;
      BATTERY_FAIL <= batfail_d;
      DEBUG_ACTIVE <= (mode_d == MODE_NORMAL_DEBUG) || (mode_d == MODE_STANDBY_DEBUG) ||
                      (mode_d == MODE_STOP_DEBUG) || (mode_d == MODE_SLEEP_DEBUG);
      MODE <= mode_d;
      debug_q <= in_debug;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_debug_no_wd_reset;
    @(posedge MCLK) disable iff (!RESET_N)
      (in_debug && !MAIN_REGULATOR_LOW) |=> (mode_q != MODE_RESET);
  endproperty
  a_debug_no_wd_reset: assert property (p_debug_no_wd_reset)
    else $error("Reset entered from debug without regulator low");

  property p_reg_low;
    @(posedge MCLK) disable iff (!RESET_N)
      (in_debug && MAIN_REGULATOR_LOW) |=> (mode_q == MODE_RESET) ##1 !RESET_OUT_N;
  endproperty
  a_reg_low: assert property (p_reg_low)
    else $error("Regulator low in debug did not force reset");

  property p_timing_to_normal;
    @(posedge MCLK) disable iff (!RESET_N)
      (mode_q == MODE_NORMAL_REQUEST && cmd.timing_write && !cmd.mode_write && !timer_done)
      |=> (mode_q == MODE_NORMAL);
  endproperty
  a_timing_to_normal: assert property (p_timing_to_normal)
    else $error("Timing write in Normal Request did not reach Normal");

  property p_arm;
    @(posedge MCLK) disable iff (!RESET_N)
      (mode_q == MODE_NORMAL && wr_arm && batfail_q) |=> armed_q;
  endproperty
  a_arm: assert property (p_arm)
    else $error("Debug not armed");

  property p_enter_debug;
    @(posedge MCLK) disable iff (!RESET_N)
      (mode_q == MODE_NORMAL && armed_q && wr_ndbg) |=> (mode_q == MODE_NORMAL_DEBUG)
      ##1 DEBUG_ACTIVE;
  endproperty
  a_enter_debug: assert property (p_enter_debug)
    else $error("Normal Debug not entered");

  property p_leave_debug;
    @(posedge MCLK) disable iff (!RESET_N)
      (mode_q == MODE_NORMAL_DEBUG && wr_arm && !MAIN_REGULATOR_LOW) |=> !in_debug;
  endproperty
  a_leave_debug: assert property (p_leave_debug)
    else $error("Debug not left on 0000 write");

  property p_wake_debug;
    @(posedge MCLK) disable iff (!RESET_N)
      ((mode_q == MODE_STOP_DEBUG || mode_q == MODE_SLEEP_DEBUG) && WAKE_UP &&
       !MAIN_REGULATOR_LOW) |=> (mode_q == MODE_NORMAL_REQUEST) && RESET_OUT_N;
  endproperty
  a_wake_debug: assert property (p_wake_debug)
    else $error("Wake from debug low power missed Normal Request");

  property p_nr_timeout;
    @(posedge MCLK) disable iff (!RESET_N)
      (mode_q == MODE_NORMAL_REQUEST && timer_done && !cmd.mode_write && !cmd.timing_write)
      |=> (mode_q == MODE_RESET) && (timer_q == 24'(RST_TICKS - 1));
  endproperty
  a_nr_timeout: assert property (p_nr_timeout)
    else $error("Normal Request timeout did not reset");

  property p_reset_release;
    @(posedge MCLK) disable iff (!RESET_N)
      (mode_q == MODE_RESET && timer_done) |=> (mode_q == MODE_NORMAL_REQUEST) ##1 RESET_OUT_N;
  endproperty
  a_reset_release: assert property (p_reset_release)
    else $error("Reset pulse did not release");

  // Even with the stop bit set, Stop Debug neither resets nor flags a watchdog fault
  property p_stop_debug_no_wd;
    @(posedge MCLK) disable iff (!RESET_N)
      (mode_q == MODE_STOP_DEBUG && WATCHDOG_IN_STOP_BIT && !WAKE_UP && !MAIN_REGULATOR_LOW &&
       !cmd.timing_write) |=> (mode_q == MODE_STOP_DEBUG) && $stable(WATCHDOG_FAIL_OUT_N);
  endproperty
  a_stop_debug_no_wd: assert property (p_stop_debug_no_wd)
    else $error("Watchdog running in Stop Debug");

  c_enter_debug: cover property (@(posedge MCLK) disable iff (!RESET_N)
    !debug_q && in_debug);
  c_wake_debug: cover property (@(posedge MCLK) disable iff (!RESET_N)
    mode_q == MODE_STOP_DEBUG ##1 mode_q == MODE_NORMAL_REQUEST);
  c_nr_timeout: cover property (@(posedge MCLK) disable iff (!RESET_N)
    mode_q == MODE_NORMAL_REQUEST ##1 mode_q == MODE_RESET);

endmodule // sbc_debug_ctrl

// ==== design/tick_divider.sv ====
// Divides the system clock into a one-cycle tick enable.
// Assumes a single clock; DIV is at least one.
`timescale 1ns/1ps
module tick_divider #(
  parameter int DIV = 200
) (
  input wire logic clk,
  input wire logic reset_n,
  output logic tick
);

  logic [15:0] cnt_q;
  wire logic wrap = (cnt_q == 16'(DIV - 1));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 16'h0000;
      tick <= 1'b0;
    end else begin
      cnt_q <= wrap ? 16'h0000 : cnt_q + 16'h0001;
      tick <= wrap;
    end
  end

endmodule // tick_divider

// ==== verif/host_model.sv ====
// Host microcontroller model: sends single SPI bytes; takes the reset line as an input but does not use it.
// Assumes bytes are taken on the rising clock edge while byte_valid is high.
`timescale 1ns/1ps
module host_model (
  // Clock and reset line from the device
  input wire logic clk,
  input wire logic rst_out_n,
  // SPI byte stream
  output logic byte_valid,
  output logic byte_write,
  output logic [7:0] byte_out
);
  initial begin
    byte_valid = 1'b0;
    byte_write = 1'b0;
    byte_out = 8'hA5;
  end

  // ****************************************************************
  // Byte transfer
  // ****************************************************************
  // Once taken, the byte lines carry the inverse so stale data never matches
  task automatic send_byte(input logic wr, input logic [7:0] b);
    @(posedge clk);
    byte_valid <= 1'b1;
    byte_write <= wr;
    byte_out <= b;
    @(posedge clk);
    byte_valid <= 1'b0;
    byte_write <= ~wr;
    byte_out <= ~b;
  endtask

  // ****************************************************************
  // Host sequences
  // ****************************************************************
  // Timing write, arm, debug select back to back inside one window
  task automatic enter_debug(input logic [7:0] dbg_byte);
    send_byte(1'b1, 8'h20);
    send_byte(1'b1, 8'h10);
    send_byte(1'b1, dbg_byte);
  endtask

  // Read the flag, then write 0000 to stay out of debug
  task automatic stay_out_of_debug();
    send_byte(1'b1, 8'h20);
    send_byte(1'b0, 8'h10);
    send_byte(1'b1, 8'h10);
  endtask

  // Pick the next debug mode straight after a wake-up
  task automatic reselect_debug(input logic [7:0] dbg_byte);
    send_byte(1'b1, dbg_byte);
  endtask
endmodule // host_model

// ==== verif/sbc_debug_ctrl_tb.sv ====
// Self-checking bench for the debug-mode watchdog bypass controller.
// Assumes the host model drives the SPI byte port; counts are shortened by parameters.
`timescale 1ns/1ps
module sbc_debug_ctrl_tb;
  import sbc_debug_pkg::*;
  localparam int TD = 2;
  localparam int NR = 20;
  localparam int RT = 5;
  localparam int WD = 50;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic reg_low = 1'b0;
  logic wake = 1'b0;
  logic wd_stop = 1'b0;
  logic spi_valid, spi_write, rst_out_n, wd_fail_n, bat_fail, dbg;
  logic [7:0] spi_byte;
  logic [3:0] mode;
  int miscompares = 0;
  int samples_checked = 0;
  int lo, hi;

  always #2.5 mclk = ~mclk;

  sbc_debug_ctrl #(.NR_TICKS(NR), .RST_TICKS(RT), .WD_TICKS(WD), .TICK_DIV(TD)) u_sbc_debug_ctrl (
    .MCLK(mclk), .RESET_N(reset_n), .SPI_BYTE_VALID(spi_valid), .SPI_BYTE_WRITE(spi_write),
    .SPI_BYTE(spi_byte), .MAIN_REGULATOR_LOW(reg_low), .WAKE_UP(wake),
    .WATCHDOG_IN_STOP_BIT(wd_stop), .RESET_OUT_N(rst_out_n), .WATCHDOG_FAIL_OUT_N(wd_fail_n),
    .BATTERY_FAIL(bat_fail), .DEBUG_ACTIVE(dbg), .MODE(mode));

  host_model u_host_model (.clk(mclk), .rst_out_n(rst_out_n), .byte_valid(spi_valid),
    .byte_write(spi_write), .byte_out(spi_byte));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      miscompares++;
    end
  endtask

  task automatic check_range(input string name, input int exp, input int got);
    samples_checked++;
    if (got < exp - TD - 1 || got > exp + TD + 1) begin
      $display("CHECK FAILED %s expected %0d seen %0d", name, exp, got);
      miscompares++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wait_mode(input logic [3:0] m, input int max);
    int n;
    n = 0;
    while (mode !== m && n < max) begin
      cyc(1);
      n++;
    end
    if (mode !== m) begin
      check("MODE wait", m, mode);
      report_and_stop();
    end
  endtask

  task automatic send(input logic wr, input logic [7:0] b);
    u_host_model.send_byte(wr, b);
    cyc(2);
  endtask

  // Counts cycles in which reset or watchdog fail shows low
  task automatic quiet(input int n, output int bad);
    bad = 0;
    repeat (n) begin
      cyc(1);
      if (rst_out_n !== 1'b1 || wd_fail_n !== 1'b1) bad++;
    end
  endtask

  task automatic power_up();
    @(posedge mclk);
    reset_n <= 1'b0;
    reg_low <= 1'b0;
    wake <= 1'b0;
    wd_stop <= 1'b0;
    cyc(16);
    check("RESET_OUT_N in reset", 8'h00, rst_out_n);
    check("WATCHDOG_FAIL_OUT_N in reset", 8'h01, wd_fail_n);
    check("MODE in reset", MODE_RESET, mode);
    check("DEBUG_ACTIVE in reset", 8'h00, dbg);
    @(posedge mclk);
    reset_n <= 1'b1;
    wait_mode(MODE_NORMAL_REQUEST, 4 * TD);
    check("BATTERY_FAIL", 8'h01, bat_fail);
    cyc(1);
    check("RESET_OUT_N", 8'h01, rst_out_n);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_unconfigured();
    lo = 0;
    hi = 0;
    while (rst_out_n !== 1'b0 && hi < 200) begin
      cyc(1);
      hi++;
    end
    hi = 0;
    while (rst_out_n === 1'b0 && lo < 200) begin
      cyc(1);
      lo++;
    end
    check("MODE after reset pulse", MODE_NORMAL_REQUEST, mode);
    while (rst_out_n === 1'b1 && hi < 200) begin
      cyc(1);
      hi++;
    end
    check_range("reset low cycles", TD * RT, lo);
    check_range("reset high cycles", TD * NR, hi);
  endtask

  task automatic t_enter_debug();
    int bad;
    power_up();
    send(1'b1, 8'h30);
    check("MODE other register", MODE_NORMAL_REQUEST, mode);
    send(1'b1, 8'h20);
    check("MODE after timing write", MODE_NORMAL, mode);
    send(1'b1, 8'h10);
    check("DEBUG_ACTIVE after arm", 8'h00, dbg);
    send(1'b1, 8'h1D);
    check("MODE normal debug", MODE_NORMAL_DEBUG, mode);
    check("DEBUG_ACTIVE", 8'h01, dbg);
    quiet(3 * WD * TD, bad);
    check("reset or fail in debug", 8'h00, 8'(bad));
  endtask

  task automatic t_stop_wake();
    int bad;
    @(posedge mclk);
    wd_stop <= 1'b1;
    send(1'b1, 8'h1C);
    check("MODE stop debug", MODE_STOP_DEBUG, mode);
    quiet(3 * WD * TD, bad);
    check("reset or fail in stop debug", 8'h00, 8'(bad));
    @(posedge mclk);
    wake <= 1'b1;
    @(posedge mclk);
    wake <= 1'b0;
    wait_mode(MODE_NORMAL_REQUEST, 4);
    u_host_model.reselect_debug(8'h16);
    cyc(2);
    check("MODE standby debug", MODE_STANDBY_DEBUG, mode);
  endtask

  task automatic t_sleep_timeout();
    send(1'b1, 8'h1E);
    check("MODE sleep debug", MODE_SLEEP_DEBUG, mode);
    @(posedge mclk);
    wake <= 1'b1;
    @(posedge mclk);
    wake <= 1'b0;
    wait_mode(MODE_NORMAL_REQUEST, 4);
    hi = 0;
    while (mode === MODE_NORMAL_REQUEST && hi < 200) begin
      cyc(1);
      hi++;
    end
    check_range("wake window cycles", TD * NR, hi);
    check("MODE after missed window", MODE_RESET, mode);
    wait_mode(MODE_NORMAL_REQUEST, TD * RT + 2 * TD);
  endtask

  task automatic t_exit_and_timeout();
    power_up();
    u_host_model.enter_debug(8'h15);
    cyc(2);
    check("MODE normal debug", MODE_NORMAL_DEBUG, mode);
    send(1'b1, 8'h10);
    check("DEBUG_ACTIVE after exit", 8'h00, dbg);
    wait_mode(MODE_RESET, WD * TD + 4 * TD);
    cyc(1);
    check("WATCHDOG_FAIL_OUT_N after timeout", 8'h00, wd_fail_n);
    wait_mode(MODE_NORMAL_REQUEST, TD * RT + 2 * TD);
    send(1'b1, 8'h20);
    check("WATCHDOG_FAIL_OUT_N after trigger", 8'h01, wd_fail_n);
  endtask

  task automatic t_regulator();
    power_up();
    u_host_model.enter_debug(8'h15);
    cyc(2);
    @(posedge mclk);
    reg_low <= 1'b1;
    cyc(2);
    check("MODE on regulator low", MODE_RESET, mode);
    check("RESET_OUT_N on regulator low", 8'h00, rst_out_n);
    @(posedge mclk);
    reg_low <= 1'b0;
  endtask

  task automatic t_opt_out();
    power_up();
    u_host_model.stay_out_of_debug();
    cyc(2);
    check("BATTERY_FAIL after read", 8'h00, bat_fail);
    send(1'b1, 8'h15);
    check("DEBUG_ACTIVE after opt out", 8'h00, dbg);
    repeat (4) begin
      cyc(TD * WD * 4 / 5);
      send(1'b1, 8'h20);
      check("MODE with triggers", MODE_NORMAL, mode);
    end
    // Plain Stop with the stop bit set keeps the watchdog, unlike Stop Debug
    @(posedge mclk);
    wd_stop <= 1'b1;
    send(1'b1, 8'h1C);
    check("MODE plain stop", MODE_STOP, mode);
    wait_mode(MODE_RESET, WD * TD + 4 * TD);
    cyc(1);
    check("WATCHDOG_FAIL_OUT_N in plain stop", 8'h00, wd_fail_n);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    power_up();
    t_unconfigured();
    t_enter_debug();
    t_stop_wake();
    t_sleep_timeout();
    t_exit_and_timeout();
    t_regulator();
    t_opt_out();
    report_and_stop();
  end
endmodule // sbc_debug_ctrl_tb
